// *** hdl/epb_pkg.sv ***
// Purpose: constants for the external parallel bus block
// Assumes: 100 MHz ref_clk_i, 8-bit register port
// Notes: register offsets are local choices, the register file is small
package epb_pkg;
   localparam logic [1:0] EPB_ADDR_PIN_FUNCTION_SELECT = 2'h0;
   localparam logic [1:0] EPB_ADDR_AUX = 2'h1;
   localparam logic [1:0] EPB_ADDR_SPEED = 2'h2;
   localparam logic [1:0] EPB_ADDR_PTR_LO = 2'h3;
   localparam logic [7:0] EPB_RST_PIN_FUNCTION_SELECT = 8'h00;
   localparam logic [7:0] EPB_RST_AUX = 8'h00;
   localparam logic [7:0] EPB_RST_SPEED = 8'hFF;
   // pin function bits
   localparam int EPB_PF_PWM = 7;
   localparam int EPB_PF_TMR3 = 6;
   localparam int EPB_PF_T2EX = 5;
   localparam int EPB_PF_SER0 = 4;
   localparam int EPB_PF_BUS_EN = 3;
   localparam int EPB_PF_CS_OE = 2;
   localparam int EPB_PF_AH_OE = 1;
   localparam int EPB_PF_AL_OE = 0;
   // auxiliary bits
   localparam int EPB_AUX_TX = 7;
   localparam int EPB_AUX_RX = 6;
   localparam int EPB_AUX_SAFE = 5;
   localparam int EPB_AUX_CLK_EN = 4;
   localparam int EPB_AUX_FLAG2 = 3;
   localparam int EPB_AUX_AUTO_INC = 2;
   localparam int EPB_AUX_PSEL = 0;
   // speed fields
   localparam int EPB_SP1_SETUP = 7;
   localparam int EPB_SP1_HOLD = 6;
   localparam int EPB_SP1_WIDTH = 4;
   localparam int EPB_SP0_HOLD = 2;
   localparam int EPB_SP0_WIDTH = 0;
   localparam logic [4:0] EPB_SETUP_SHORT = 5'h02;
   localparam logic [4:0] EPB_SETUP_LONG = 5'h03;
   localparam logic [4:0] EPB_HOLD_SHORT = 5'h01;
   localparam logic [4:0] EPB_HOLD_LONG = 5'h02;
   localparam logic [3:0] EPB_LCLK_DIV = 4'hC;
   localparam logic [15:0] EPB_LOWER_BASE = 16'h4000;
   typedef enum logic [3:0] {
      EPB_IDLE = 4'b0001,
      EPB_SETUP = 4'b0010,
      EPB_STROBE = 4'b0100,
      EPB_HOLD = 4'b1000
   } epb_state_e;
endpackage

// *** hdl/epb_bus.sv ***
// Purpose: external parallel bus engine with pin muxing and pointers
// Assumes: core issues one-cycle move requests; host port disable is a strap-like input
// Notes: lower region setup is fixed at two cycles; speed bit 3 is stored but unused
//
// Notes on behaviour
// - bus enable routes data and strobes
// - read strobe low, data captured on rise
// - write strobe low only during writes
// - lower select low for 4000h to 7FFFh
// - inverted bit on latch pin or other
// - select output off drives no select
// - high address byte on port 2 for pointer moves
// - port 0 multiplexes address and data
// - direct low address on port 4 pins
// - latch strobe high marks address valid
// - idle latch pin gives clock by twelve
// - clock disabled gives only latch pulses
// - pulses during access, divided clock idle
// - width codes give 2,4,8,16 cycles
// - upper setup two or three cycles
// - hold one or two cycles
// - auto increment active pointer after move
// - select bit chooses one of two pointers
// - auxiliary flags read-only, one user flag
// - higher priority function wins shared pin
// - remap bits move peripheral pins
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module epb_bus (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic mov_req_i,
   input wire logic mov_write_i,
   input wire logic mov_use_ptr_i,
   input wire logic [15:0] mov_addr_i,
   input wire logic [7:0] mov_wdata_i,
   output logic mov_busy_o,
   output logic mov_done_o,
   output logic [7:0] mov_rdata_o,
   input wire logic ser0_tx_active_i,
   input wire logic ser0_rx_active_i,
   input wire logic safe_mode_active_i,
   input wire logic host_port1_disable_i,
   input wire logic pwm_claim_i,
   output logic [7:0] port0_o,
   output logic [7:0] port0_oe_n_o,
   input wire logic [7:0] port0_i,
   output logic [7:0] port2_o,
   output logic [7:0] port2_en_o,
   output logic [5:0] port4_o,
   output logic addr6_o,
   output logic write_strobe_n_o,
   output logic read_strobe_n_o,
   output logic lower_region_select_n_o,
   output logic top_select_p33_n_o,
   output logic top_select_p55_n_o,
   output logic top_select_p33_en_o,
   output logic top_select_p55_en_o,
   output logic latch_pin_o,
   output logic latch_pin_en_o,
   output logic [3:0] remap_o
);
   import epb_pkg::*;

   logic [7:0] pin_function_select;
   logic [7:0] aux_rw;
   logic [7:0] speed;
   logic [15:0] ptr0;
   logic [15:0] ptr1;
   epb_state_e state;
   logic [4:0] cnt;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic is_write;
   logic used_ptr;
   logic [3:0] lclk_cnt;
   logic [7:0] aux_view;
   logic bus_en;
   logic upper;
   logic [4:0] setup_len;
   logic [4:0] hold_len;
   logic [4:0] width_len;
   logic [1:0] wcode;
   logic [15:0] act_addr;
   logic latch_active;

   assign bus_en = pin_function_select[EPB_PF_BUS_EN];
   assign upper = addr[15];

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   assign aux_view = {ser0_tx_active_i, ser0_rx_active_i, safe_mode_active_i,
                      aux_rw[EPB_AUX_CLK_EN], aux_rw[EPB_AUX_FLAG2],
                      aux_rw[EPB_AUX_AUTO_INC], 1'b0, aux_rw[EPB_AUX_PSEL]};

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         pin_function_select <= EPB_RST_PIN_FUNCTION_SELECT;
         aux_rw <= EPB_RST_AUX;
         speed <= EPB_RST_SPEED;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            EPB_ADDR_PIN_FUNCTION_SELECT: pin_function_select <= reg_wdata_i;
            EPB_ADDR_AUX: aux_rw <= reg_wdata_i & 8'h1D;
            EPB_ADDR_SPEED: speed <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            EPB_ADDR_PIN_FUNCTION_SELECT: reg_rdata_o <= pin_function_select;
            EPB_ADDR_AUX: reg_rdata_o <= aux_view;
            EPB_ADDR_SPEED: reg_rdata_o <= speed;
            default: reg_rdata_o <= aux_rw[EPB_AUX_PSEL] ? ptr1[7:0] : ptr0[7:0];
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // timing selection
   // ---------------------------------------------------------------
   assign wcode = upper ? speed[EPB_SP1_WIDTH +: 2] : speed[EPB_SP0_WIDTH +: 2];
   assign width_len = 5'h02 << wcode;
   assign setup_len = (upper && speed[EPB_SP1_SETUP]) ? EPB_SETUP_LONG
                                                      : EPB_SETUP_SHORT;
   assign hold_len = (upper ? speed[EPB_SP1_HOLD] : speed[EPB_SP0_HOLD])
                     ? EPB_HOLD_LONG : EPB_HOLD_SHORT;
   assign act_addr = !mov_use_ptr_i ? mov_addr_i
                   : (aux_rw[EPB_AUX_PSEL] ? ptr1 : ptr0);

   // ---------------------------------------------------------------
   // access sequencer
   // ---------------------------------------------------------------
   // a request during an access is ignored; the core waits on busy
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state <= EPB_IDLE;
         cnt <= 5'h00;
         addr <= 16'h0000;
         wdata <= 8'h00;
         is_write <= 1'b0;
         used_ptr <= 1'b0;
      end else begin
         case (state)
            EPB_IDLE: begin
               if (mov_req_i && bus_en) begin
                  state <= EPB_SETUP;
                  addr <= act_addr;
                  wdata <= mov_wdata_i;
                  is_write <= mov_write_i;
                  used_ptr <= mov_use_ptr_i;
                  cnt <= 5'h01;
               end
            end
            EPB_SETUP: begin
               if (cnt >= setup_len) begin
                  state <= EPB_STROBE;
                  cnt <= 5'h01;
               end else begin
                  cnt <= cnt + 5'h01;
               end
            end
            EPB_STROBE: begin
               if (cnt >= width_len) begin
                  state <= EPB_HOLD;
                  cnt <= 5'h01;
               end else begin
                  cnt <= cnt + 5'h01;
               end
            end
            EPB_HOLD: begin
               if (cnt >= hold_len) begin
                  state <= EPB_IDLE;
                  cnt <= 5'h00;
               end else begin
                  cnt <= cnt + 5'h01;
               end
            end
            default: state <= EPB_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         mov_rdata_o <= 8'h00;
      end else if (state == EPB_STROBE && cnt >= width_len && !is_write) begin
         mov_rdata_o <= port0_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         mov_done_o <= 1'b0;
      end else begin
         mov_done_o <= (state == EPB_HOLD) && (cnt >= hold_len);
      end
   end

   // ---------------------------------------------------------------
   // data pointers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ptr0 <= 16'h0000;
         ptr1 <= 16'h0000;
      end else if (state == EPB_HOLD && cnt >= hold_len && used_ptr
                   && aux_rw[EPB_AUX_AUTO_INC]) begin
         if (aux_rw[EPB_AUX_PSEL]) begin
            ptr1 <= ptr1 + 16'h0001;
         end else begin
            ptr0 <= ptr0 + 16'h0001;
         end
      end else if (reg_wr_i && reg_addr_i == EPB_ADDR_PTR_LO) begin
         if (aux_rw[EPB_AUX_PSEL]) begin
            ptr1 <= {ptr1[15:8], reg_wdata_i};
         end else begin
            ptr0 <= {ptr0[15:8], reg_wdata_i};
         end
      end
   end

   // ---------------------------------------------------------------
   // latch pin clock, one high cycle in twelve
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         lclk_cnt <= 4'h0;
      end else if (lclk_cnt == EPB_LCLK_DIV - 4'h1) begin
         lclk_cnt <= 4'h0;
      end else begin
         lclk_cnt <= lclk_cnt + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // pin drive
   // ---------------------------------------------------------------
   assign mov_busy_o = (state != EPB_IDLE);
   assign latch_active = host_port1_disable_i
      && (aux_rw[EPB_AUX_CLK_EN] || (bus_en && !pin_function_select[EPB_PF_AL_OE]));

   always_comb begin
      port0_o = wdata;
      port0_oe_n_o = 8'hFF;
      if (bus_en && state != EPB_IDLE) begin
         if (!pin_function_select[EPB_PF_AL_OE] && state == EPB_SETUP) begin
            port0_o = addr[7:0];
            port0_oe_n_o = 8'h00;
         end else if (is_write) begin
            port0_oe_n_o = 8'h00;
         end
      end
   end

   // pwm claim outranks the high address byte on P2.4/P2.5
   always_comb begin
      port2_o = addr[15:8];
      port2_en_o = 8'h00;
      if (bus_en && pin_function_select[EPB_PF_AH_OE] && used_ptr && state != EPB_IDLE) begin
         port2_en_o = 8'hFF;
         if (pwm_claim_i && !pin_function_select[EPB_PF_PWM]) begin
            port2_en_o[5:4] = 2'b00;
         end
      end
      if (bus_en && pin_function_select[EPB_PF_AL_OE]) begin
         port2_o[7] = addr[7];
         port2_en_o[7] = (state != EPB_IDLE);
      end
   end

   assign port4_o = addr[5:0];
   assign addr6_o = addr[6];
   assign write_strobe_n_o = !(bus_en && state == EPB_STROBE && is_write);
   assign read_strobe_n_o = !(bus_en && state == EPB_STROBE && !is_write);
   assign lower_region_select_n_o = !(bus_en && pin_function_select[EPB_PF_CS_OE]
      && state != EPB_IDLE && addr[15:14] == EPB_LOWER_BASE[15:14]);
   assign top_select_p33_n_o = !(state != EPB_IDLE && addr[15]);
   assign top_select_p55_n_o = top_select_p33_n_o;
   assign top_select_p33_en_o = bus_en && pin_function_select[EPB_PF_CS_OE] && !latch_active;
   assign top_select_p55_en_o = bus_en && pin_function_select[EPB_PF_CS_OE] && latch_active;
   assign latch_pin_en_o = latch_active;

   always_comb begin
      latch_pin_o = 1'b0;
      if (bus_en && !pin_function_select[EPB_PF_AL_OE] && state != EPB_IDLE) begin
         latch_pin_o = (state == EPB_SETUP) && (cnt == 5'h01);
      end else if (aux_rw[EPB_AUX_CLK_EN] && state == EPB_IDLE) begin
         latch_pin_o = (lclk_cnt == 4'h0);
      end
   end

   assign remap_o = pin_function_select[EPB_PF_PWM:EPB_PF_SER0];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_WR_ONLY_WRITE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !write_strobe_n_o |-> is_write && state == EPB_STROBE)
      else $error("write strobe outside write access");
   AST_RD_CAPTURE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!read_strobe_n_o && cnt >= width_len) |=> mov_rdata_o == $past(port0_i))
      else $error("read data not captured");
   AST_LOWER_SEL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !lower_region_select_n_o |-> addr[15:14] == 2'b01)
      else $error("lower select outside range");
   AST_TOP_PIN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !(top_select_p33_en_o && top_select_p55_en_o))
      else $error("both top select pins enabled");
   AST_NO_SEL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !pin_function_select[EPB_PF_CS_OE] |-> !top_select_p33_en_o && !top_select_p55_en_o)
      else $error("select driven while disabled");
   AST_SETUP_LEN: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(state == EPB_STROBE) |-> $past(cnt) == setup_len)
      else $error("setup time wrong");
   AST_WIDTH: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $rose(state == EPB_HOLD) |-> $past(cnt) == width_len)
      else $error("strobe width wrong");
   AST_ORDER: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      state == EPB_IDLE && $past(state) != EPB_IDLE |-> $past(state) == EPB_HOLD)
      else $error("access sequence out of order");
   AST_INC: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mov_done_o && used_ptr && aux_rw[EPB_AUX_AUTO_INC] && !aux_rw[EPB_AUX_PSEL]
       && $stable(aux_rw)) |-> ptr0 == $past(ptr0) + 16'h0001)
      else $error("pointer increment timing");
   COV_READ: cover property (@(posedge ref_clk_i) mov_done_o && !is_write);
   COV_WRITE: cover property (@(posedge ref_clk_i) mov_done_o && is_write);
   COV_UPPER: cover property (@(posedge ref_clk_i) !top_select_p33_n_o && mov_busy_o);
endmodule // epb_bus

// *** dv/epb_ext_mem.sv ***
// Purpose: external memory chip hanging on the parallel bus
// Assumes: low address is taken from the data lines while the latch pin is high
// Notes: only the low address byte selects a cell; the high byte is ignored
`timescale 1ns/10ps
module epb_ext_mem (
   input wire logic ref_clk_i,
   input wire logic [7:0] bus_data_i,
   input wire logic latch_i,
   input wire logic write_n_i,
   input wire logic read_n_i,
   output logic [7:0] dq_o
);
   logic [7:0] mem [0:255];
   logic [7:0] low_addr = 8'h00;
   logic [7:0] last_dq = 8'h00;
   // -----------------------------------------------------------------
   // address latch and data lines
   // -----------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (latch_i) begin
         low_addr <= bus_data_i;
      end
      if (!read_n_i) begin
         last_dq <= mem[low_addr];
      end
   end
   always @(posedge write_n_i) begin
      mem[low_addr] = bus_data_i;
   end
   // no pull-up on the data lines, so a released bus shows the inverse value
   assign dq_o = !read_n_i ? mem[low_addr] : ~last_dq;
endmodule // epb_ext_mem

// *** dv/external_parallel_bus_test.sv ***
// Purpose: self-checking bench for the external parallel bus
// Assumes: pointer high bytes reset to zero; memory model keys on the low byte
// Notes: host port disabled so the latch pin belongs to the bus
`timescale 1ns/10ps
module external_parallel_bus_test;
   import epb_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr = 1'b0, reg_rd = 1'b0, mov_req = 1'b0, mov_write = 1'b0, mov_use_ptr = 1'b0;
   logic tx_act = 1'b1, rx_act = 1'b0, safe_act = 1'b1, pwm = 1'b0, host_dis = 1'b1;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, mov_wdata = 8'h00;
   logic [15:0] mov_addr = 16'h0000;
   logic [7:0] reg_rdata, port0, port0_oe_n, port2, mem_dq, mov_rdata, rdata, port2_en, p2_en;
   logic [5:0] port4;
   logic addr6;
   logic busy, done, wr_n, rd_n, cs0_n, t33_n, t55_n, t33_en, t55_en, latch, latch_en;
   logic [3:0] remap;
   int bad_count = 0;
   int tests_run = 0;
   int n, w_lo, r_lo, cs_lo, top_lo, lat_hi, p2_bad, dir_ok, bsy;
   wire [7:0] port0_in = (port0 & ~port0_oe_n) | (mem_dq & port0_oe_n);

   epb_bus epb_bus_inst (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .mov_req_i(mov_req), .mov_write_i(mov_write), .mov_use_ptr_i(mov_use_ptr),
      .mov_addr_i(mov_addr), .mov_wdata_i(mov_wdata), .mov_busy_o(busy), .mov_done_o(done),
      .mov_rdata_o(mov_rdata), .ser0_tx_active_i(tx_act), .ser0_rx_active_i(rx_act),
      .safe_mode_active_i(safe_act), .host_port1_disable_i(host_dis), .pwm_claim_i(pwm),
      .port0_o(port0), .port0_oe_n_o(port0_oe_n), .port0_i(port0_in), .port2_o(port2),
      .port2_en_o(port2_en), .port4_o(port4), .addr6_o(addr6), .write_strobe_n_o(wr_n),
      .read_strobe_n_o(rd_n), .lower_region_select_n_o(cs0_n),
      .top_select_p33_n_o(t33_n), .top_select_p55_n_o(t55_n),
      .top_select_p33_en_o(t33_en), .top_select_p55_en_o(t55_en), .latch_pin_o(latch),
      .latch_pin_en_o(latch_en), .remap_o(remap));
   epb_ext_mem epb_ext_mem_inst (.ref_clk_i(ref_clk), .bus_data_i(port0), .latch_i(latch),
      .write_n_i(wr_n), .read_n_i(rd_n), .dq_o(mem_dq));

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [1:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rdata = reg_rdata;
   endtask
   // counts cycles to completion, strobe, latch and busy cycles, and what the other pins did while a strobe was low
   task automatic move(input logic wr, input logic ptr, input logic [15:0] a,
         input logic [7:0] d);
      @(posedge ref_clk);
      mov_req <= 1'b1;
      mov_write <= wr;
      mov_use_ptr <= ptr;
      mov_addr <= a;
      mov_wdata <= d;
      @(posedge ref_clk);
      mov_req <= 1'b0;
      n = 0; w_lo = 0; r_lo = 0; cs_lo = 0; top_lo = 0; lat_hi = 0; p2_bad = 0;
      dir_ok = 0;
      bsy = 0;
      p2_en = 8'h00;
      do begin
         #1;
         n++;
         w_lo += (wr_n === 1'b0);
         r_lo += (rd_n === 1'b0);
         lat_hi += (latch === 1'b1);
         bsy += (busy === 1'b1);
         if (wr_n !== 1'b1 || rd_n !== 1'b1) begin
            p2_en = port2_en;
            dir_ok += ({port2[7], addr6, port4} === a[7:0]);
            cs_lo += (cs0_n === 1'b0);
            top_lo += (t55_n === 1'b0);
            p2_bad += (!ptr && port2 !== a[15:8]);
         end
         if (done !== 1'b1) @(posedge ref_clk);
      end while (done !== 1'b1 && n < 100);
   endtask
   task automatic count_latch();
      lat_hi = 0;
      repeat (24) begin
         @(posedge ref_clk);
         #1;
         lat_hi += (latch === 1'b1);
      end
   endtask
   task automatic conclude();
      if (bad_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // clock, watchdog and test sequence
   // -----------------------------------------------------------------
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      reg_read(EPB_ADDR_PIN_FUNCTION_SELECT);
      check(rdata, EPB_RST_PIN_FUNCTION_SELECT);
      reg_read(EPB_ADDR_SPEED);
      check(rdata, EPB_RST_SPEED);
      reg_write(EPB_ADDR_AUX, 8'hFF);
      reg_read(EPB_ADDR_AUX);
      check(rdata, 8'hBD);
      count_latch();
      check(lat_hi, 2);
      reg_write(EPB_ADDR_AUX, 8'h00);
      reg_write(EPB_ADDR_PIN_FUNCTION_SELECT, 8'hF0);
      #1 check(remap, 4'hF);
      move(1'b1, 1'b0, 16'h4000, 8'h11);
      check(w_lo + n, 100);
      reg_write(EPB_ADDR_PIN_FUNCTION_SELECT, 8'h0E);
      count_latch();
      check(lat_hi, 0);
      for (int c = 0; c < 4; c++) begin
         reg_write(EPB_ADDR_SPEED, c[7:0]);
         move(1'b1, 1'b0, 16'h7FFC + c[15:0], 8'hA0 + c[7:0]);
         check(w_lo, 2 << c);
         check(cs_lo, 2 << c);
         check(n, (2 << c) + 4);
         check(bsy, (2 << c) + 3);
         check(lat_hi + r_lo + p2_bad + p2_en, 1);
      end
      reg_write(EPB_ADDR_SPEED, 8'h04);
      move(1'b0, 1'b0, 16'h7FFE, 8'h00);
      check(mov_rdata, 8'hA2);
      check(n, 7);
      check(r_lo * 16 + w_lo, 16'h20);
      reg_write(EPB_ADDR_SPEED, 8'hC0);
      move(1'b1, 1'b0, 16'h8001, 8'h5C);
      check(n, 8);
      check(top_lo * 16 + cs_lo, 16'h20);
      check({t55_en, t33_en}, 2'b10);
      move(1'b1, 1'b0, 16'h3FFF, 8'h33);
      check(top_lo + cs_lo, 0);
      reg_write(EPB_ADDR_PIN_FUNCTION_SELECT, 8'h0F);
      move(1'b0, 1'b0, 16'h40A5, 8'h00);
      check(lat_hi * 16 + dir_ok, 2);
      check({t55_en, t33_en}, 2'b01);
      reg_write(EPB_ADDR_PIN_FUNCTION_SELECT, 8'h0E);
      reg_write(EPB_ADDR_PTR_LO, 8'h3F);
      reg_write(EPB_ADDR_AUX, 8'h04);
      pwm <= 1'b1;
      move(1'b1, 1'b1, 16'h0000, 8'h77);
      check(p2_en, 8'hCF);
      reg_write(EPB_ADDR_AUX, 8'h01);
      reg_write(EPB_ADDR_PTR_LO, 8'h3F);
      pwm <= 1'b0;
      move(1'b0, 1'b1, 16'h0000, 8'h00);
      check(mov_rdata, 8'h77);
      check(p2_en, 8'hFF);
      reg_read(EPB_ADDR_PTR_LO);
      check(rdata, 8'h3F);
      reg_write(EPB_ADDR_AUX, 8'h04);
      reg_read(EPB_ADDR_PTR_LO);
      check(rdata, 8'h40);
      @(posedge ref_clk);
      host_dis <= 1'b0;
      @(posedge ref_clk);
      #1;
      check({latch_en, t55_en, t33_en}, 3'b001);
      conclude();
   end
endmodule // external_parallel_bus_test
